// ---- event_ctrl.sv ----
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "event_ctrl_params.svh"

module event_ctrl (
    input  wire logic                           core_clk,
    input  wire logic                           arst_n,
    input  wire logic [`SYS_W-1:0]              periph_irq,
    input  wire logic [`CORE_W-1:0]             dedicated_evt,
    input  wire logic                           supervisor,
    input  wire logic                           global_irq_on_instr,
    input  wire logic                           global_irq_off_instr,
    input  wire logic                           svc_accept,
    input  wire logic                           svc_return,
    input  wire logic                           powered_down,
    input  wire event_ctrl_pkg::reg_req_s       req,
    output logic [`CORE_W-1:0]                  core_event_pending,
    output event_ctrl_pkg::ctrl_out_s           ctrl_out
);
    import event_ctrl_pkg::*;

    ctrl_state_s                st_r;
    ctrl_state_s                st_nxt;
    logic [`CORE_W-1:0]         gp_in;
    logic [`CORE_W-1:0]         rise;
    logic [`CORE_W-1:0]         ready;
    logic [`CORE_W-1:0]         entry;
    logic [`CORE_W-1:0]         ret_clr;
    logic                       found;
    level_t                     top_pend;

    // ----------------------------------------------------------------
    // System routing stage
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < `CORE_W; g++) begin : g_level
            logic [`SYS_W-1:0] hit;
            for (genvar s = 0; s < `SYS_W; s++) begin : g_src
                assign hit[s] = st_r.src_d1[s] & st_r.sys_mask[s] &
                                (st_r.assign_map[`LVL_W*s +: `LVL_W] == 4'(g));
            end
            // Only general levels take routed sources; the rest come in directly
            assign gp_in[g] = (g >= `FIRST_GP_LEVEL) ? (|hit) : dedicated_evt[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Core stage: edge capture, priority pick
    // ----------------------------------------------------------------
    // Edge seen across two registered stages, so latch lands two cycles later
    assign rise = st_r.gp_in_d1 & ~st_r.gp_in_d2;

    always_comb begin
        ready = st_r.latch & st_r.mask;
        if (!st_r.global_en) begin
            ready[`LAST_GP_LEVEL:`FIRST_GP_LEVEL] = 9'h000;
        end
    end

    // Lowest index wins; it must outrank the lowest-index active pending level
    always_comb begin
        entry    = `ZERO16;
        found    = 1'b0;
        top_pend = 4'hf;
        for (int i = `CORE_W-1; i >= 0; i--) begin
            if (st_r.pend[i]) begin
                top_pend = 4'(i);
            end
        end
        for (int i = 0; i < `CORE_W; i++) begin
            if (!found && ready[i] && (!(|st_r.pend) || 4'(i) < top_pend)) begin
                entry[i] = 1'b1;
                found    = 1'b1;
            end
        end
        ret_clr = `ZERO16;
        if (svc_return && (|st_r.pend)) begin
            ret_clr[top_pend] = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        st_nxt.src_d1    = periph_irq;
        st_nxt.gp_in_d1  = gp_in;
        st_nxt.gp_in_d2  = st_r.gp_in_d1;
        st_nxt.svc_valid = 1'b0;

        // New edge wins over the acceptance clear so a queued event survives
        st_nxt.latch = (st_r.latch & ~(svc_accept ? entry : `ZERO16)) | rise;
        if (svc_accept && found) begin
            st_nxt.pend      = (st_r.pend & ~ret_clr) | entry;
            st_nxt.svc_valid = 1'b1;
            for (int i = 0; i < `CORE_W; i++) begin
                if (entry[i]) begin
                    st_nxt.svc_level = 4'(i);
                end
            end
        end else begin
            st_nxt.pend = st_r.pend & ~ret_clr;
        end

        if (global_irq_on_instr) begin
            st_nxt.global_en = 1'b1;
        end else if (global_irq_off_instr) begin
            st_nxt.global_en = 1'b0;
        end

        st_nxt.wake = powered_down && (|(st_r.src_d1 & st_r.sys_wake));

        if (req.wr) begin
            case (req.addr)
                `REG_CORE_MASK: begin
                    if (supervisor) begin
                        st_nxt.mask = req.wdata[`CORE_W-1:0];
                    end
                end
                `REG_SYS_MASK:  st_nxt.sys_mask = req.wdata;
                `REG_SYS_WAKE:  st_nxt.sys_wake = req.wdata;
                `REG_ASSIGN0:   st_nxt.assign_map[31:0]   = req.wdata;
                `REG_ASSIGN1:   st_nxt.assign_map[63:32]  = req.wdata;
                `REG_ASSIGN2:   st_nxt.assign_map[95:64]  = req.wdata;
                `REG_ASSIGN3:   st_nxt.assign_map[127:96] = req.wdata;
                default: ;
            endcase
        end

        st_nxt.rdata = `ZERO32;
        if (req.rd) begin
            case (req.addr)
                // Core registers answer zero outside supervisor mode
                `REG_CORE_LATCH: st_nxt.rdata = supervisor ? {16'h0000, st_r.latch} : `ZERO32;
                `REG_CORE_MASK:  st_nxt.rdata = supervisor ? {16'h0000, st_r.mask}  : `ZERO32;
                `REG_CORE_PEND:  st_nxt.rdata = supervisor ? {16'h0000, st_r.pend}  : `ZERO32;
                `REG_SYS_MASK:   st_nxt.rdata = st_r.sys_mask;
                `REG_SYS_STATUS: st_nxt.rdata = st_r.src_d1;
                `REG_SYS_WAKE:   st_nxt.rdata = st_r.sys_wake;
                `REG_ASSIGN0:    st_nxt.rdata = st_r.assign_map[31:0];
                `REG_ASSIGN1:    st_nxt.rdata = st_r.assign_map[63:32];
                `REG_ASSIGN2:    st_nxt.rdata = st_r.assign_map[95:64];
                `REG_ASSIGN3:    st_nxt.rdata = st_r.assign_map[127:96];
                `REG_RET_LEVEL:  st_nxt.rdata = {28'h0000000, top_pend};
                default:         st_nxt.rdata = `ZERO32;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_r            <= '0;
            st_r.assign_map <= {`ASSIGN3_RST, `ASSIGN2_RST, `ASSIGN1_RST, `ASSIGN0_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign core_event_pending  = st_r.pend;
    assign ctrl_out.svc_valid  = st_r.svc_valid;
    assign ctrl_out.svc_level  = st_r.svc_level;
    assign ctrl_out.wake       = st_r.wake;
    assign ctrl_out.rdata      = st_r.rdata;

endmodule : event_ctrl
`default_nettype wire

// ---- event_ctrl_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "event_ctrl_params.svh"
module event_ctrl_monitor
    import event_ctrl_pkg::*;
(
    input wire logic                     core_clk,
    input wire logic                     arst_n,
    input wire logic [`SYS_W-1:0]        periph_irq,
    input wire logic                     supervisor,
    input wire logic                     svc_accept,
    input wire logic                     powered_down,
    input wire event_ctrl_pkg::reg_req_s req,
    input wire logic [`CORE_W-1:0]       core_event_pending,
    input wire event_ctrl_pkg::ctrl_out_s ctrl_out
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    rdata_idle_a: assert property (!$past(req.rd) |-> ctrl_out.rdata == 32'h0)
        else $error("read data outside read slot");
    unmapped_read_a: assert property (req.rd && req.addr > 4'ha |=> ctrl_out.rdata == 32'h0)
        else $error("unmapped read not zero");
    status_read_a: assert property (req.rd && req.addr == 4'h4 |=> ctrl_out.rdata == $past(periph_irq, 2))
        else $error("status does not follow sources");
    core_priv_a: assert property (req.rd && !supervisor && req.addr <= 4'h2 |=> ctrl_out.rdata == 32'h0)
        else $error("core register read outside supervisor");
    core_width_a: assert property (req.rd && req.addr <= 4'h2 |=> ctrl_out.rdata[31:16] == 16'h0)
        else $error("core register wider than 16 bits");
    svc_pend_a: assert property (ctrl_out.svc_valid |-> core_event_pending[ctrl_out.svc_level])
        else $error("entered event not pending");
    svc_accept_a: assert property (ctrl_out.svc_valid |-> $past(svc_accept))
        else $error("event entered without accept");
    wake_gate_a: assert property (ctrl_out.wake |-> $past(powered_down))
        else $error("wake while running");
    min_latency_a: assert property ($rose(periph_irq[19]) && !core_event_pending[13]
        |=> !core_event_pending[13] [*2])
        else $error("pending set too early");
    cover property (ctrl_out.svc_valid && ctrl_out.svc_level == 4'hd);
    cover property (ctrl_out.wake);
    cover property (req.rd && req.addr == 4'h4);
endmodule : event_ctrl_monitor
bind event_ctrl event_ctrl_monitor event_ctrl_monitor_inst (.core_clk(core_clk), .arst_n(arst_n),
    .periph_irq(periph_irq), .supervisor(supervisor), .svc_accept(svc_accept), .powered_down(powered_down),
    .req(req), .core_event_pending(core_event_pending), .ctrl_out(ctrl_out));
`default_nettype wire

// ---- event_ctrl_params.svh ----
`ifndef EVENT_CTRL_PARAMS_SVH
`define EVENT_CTRL_PARAMS_SVH

// Register offsets (index on the plain register port)
`define REG_CORE_LATCH    4'h0
`define REG_CORE_MASK     4'h1
`define REG_CORE_PEND     4'h2
`define REG_SYS_MASK      4'h3
`define REG_SYS_STATUS    4'h4
`define REG_SYS_WAKE      4'h5
`define REG_ASSIGN0       4'h6
`define REG_ASSIGN1       4'h7
`define REG_ASSIGN2       4'h8
`define REG_ASSIGN3       4'h9
`define REG_RET_LEVEL     4'ha

// Widths
`define CORE_W            16
`define SYS_W             32
`define LVL_W             4
`define ADDR_W            4

// Core event classes
`define FIRST_GP_LEVEL    4'h7
`define LAST_GP_LEVEL     4'hf

// Default source to level routing, 4 bits per source, source 0 in low nibble
`define ASSIGN0_RST       32'h88887707
`define ASSIGN1_RST       32'hbbaaaa99
`define ASSIGN2_RST       32'h000ddccb
`define ASSIGN3_RST       32'h000fe000

`define ZERO16            16'h0000
`define ZERO32            32'h00000000

`endif

// ---- event_ctrl_pkg.sv ----
package event_ctrl_pkg;
    `include "event_ctrl_params.svh"

    typedef logic [`ADDR_W-1:0] reg_addr_t;
    typedef logic [`LVL_W-1:0]  level_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        reg_addr_t   addr;
        logic [31:0] wdata;
    } reg_req_s;

    typedef struct packed {
        logic        svc_valid;
        level_t      svc_level;
        logic        wake;
        logic [31:0] rdata;
    } ctrl_out_s;

    typedef struct packed {
        logic [`SYS_W-1:0]     src_d1;
        logic [`SYS_W-1:0]     sys_mask;
        logic [`SYS_W-1:0]     sys_wake;
        logic [4*`SYS_W-1:0]   assign_map;
        logic [`CORE_W-1:0]    gp_in_d1;
        logic [`CORE_W-1:0]    gp_in_d2;
        logic [`CORE_W-1:0]    latch;
        logic [`CORE_W-1:0]    mask;
        logic [`CORE_W-1:0]    pend;
        logic                  global_en;
        logic                  svc_valid;
        level_t                svc_level;
        logic                  wake;
        logic [31:0]           rdata;
    } ctrl_state_s;
endpackage : event_ctrl_pkg

// ---- event_ctrl_test.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "event_ctrl_params.svh"
module event_ctrl_test;
    import event_ctrl_pkg::*;
    logic              core_clk, arst_n, supervisor, on_i, off_i, svc_accept, svc_return, pd;
    logic [`SYS_W-1:0] irq;
    logic [15:0]       pend;
    reg_req_s          req;
    ctrl_out_s         co;
    int                mismatches, n_compared, lat;
    event_ctrl event_ctrl_inst (.core_clk(core_clk), .arst_n(arst_n), .periph_irq(irq), .dedicated_evt(16'h0000),
        .supervisor(supervisor), .global_irq_on_instr(on_i), .global_irq_off_instr(off_i), .svc_accept(svc_accept),
        .svc_return(svc_return), .powered_down(pd), .req(req), .core_event_pending(pend), .ctrl_out(co));
    pipe_model pipe_model_inst (.core_clk(core_clk), .arst_n(arst_n), .svc_valid(co.svc_valid),
        .svc_accept(svc_accept), .svc_return(svc_return));
    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        req.addr  <= a;
        req.wdata <= d;
        req.wr    <= 1'b1;
        @(posedge core_clk);
        req.wr <= 1'b0;
    endtask : wr
    // Read data is only valid in the single cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
        req.addr <= a;
        req.rd   <= 1'b1;
        @(posedge core_clk);
        req.rd <= 1'b0;
        #1 check(co.rdata & m, e);
        @(posedge core_clk);
    endtask : rd
    task automatic instr(input logic en);
        on_i  <= en;
        off_i <= !en;
        @(posedge core_clk);
        on_i  <= 1'b0;
        off_i <= 1'b0;
    endtask : instr
    task automatic wait_pend(input int idx);
        lat = 0;
        while (pend[idx] !== 1'b1 && lat < 80) begin
            @(posedge core_clk);
            #1 lat++;
        end
    endtask : wait_pend
    task automatic wrap_up();
        $display("compared=%0d mismatches=%0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up
    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    initial begin
        #20000 mismatches++;
        wrap_up();
    end
    initial begin
        {arst_n, supervisor, on_i, off_i, pd, irq, req} = '0;
        {mismatches, n_compared} = '0;
        repeat (6) @(posedge core_clk);
        arst_n     <= 1'b1;
        supervisor <= 1'b1;
        @(posedge core_clk);
        for (int a = 0; a < 6; a++) rd(a[3:0], 32'hffffffff, 32'h0);
        rd(4'ha, 32'hffffffff, 32'h0000000f);
        rd(4'h6, 32'hffffffff, 32'h88887707);
        rd(4'h7, 32'hffffffff, 32'hbbaaaa99);
        rd(4'h8, 32'hffffffff, 32'h000ddccb);
        wr(4'h7, 32'h12345678);
        rd(4'h7, 32'hffffffff, 32'h12345678);
        wr(4'h7, 32'hbbaaaa99);
        rd(4'h9, 32'h000fffff, 32'h000fe000);
        rd(4'hb, 32'hffffffff, 32'h0);
        supervisor <= 1'b0;
        wr(4'h1, 32'hffffffff);
        rd(4'h1, 32'hffffffff, 32'h0);
        supervisor <= 1'b1;
        rd(4'h1, 32'hffffffff, 32'h0);
        wr(4'h1, 32'hffff6000);
        rd(4'h1, 32'hffffffff, 32'h00006000);
        wr(4'h3, 32'hffffffff);
        rd(4'h3, 32'hffffffff, 32'hffffffff);
        wr(4'h5, 32'h00080000);
        instr(1'b1);
        pd      <= 1'b1;
        irq[19] <= 1'b1;
        wait_pend(13);
        check(32'(co.svc_valid), 32'h1);
        check(32'(lat >= 4 && lat < 80), 32'h1);
        check(32'(co.svc_level), 32'hd);
        check(32'(co.wake), 32'h1);
        rd(4'h0, 32'hffffffff, 32'h0);
        rd(4'h4, 32'h00180000, 32'h00080000);
        rd(4'ha, 32'hffffffff, 32'h0000000d);
        {pd, irq[19]} <= 2'b00;
        instr(1'b0);
        {irq[28], irq[27]} <= 2'b11;
        repeat (10) @(posedge core_clk);
        rd(4'h0, 32'hffffffff, 32'h0000c000);
        instr(1'b1);
        wait_pend(14);
        check(32'(co.svc_level), 32'he);
        {irq[28], irq[27]} <= 2'b00;
        repeat (60) @(posedge core_clk);
        rd(4'h0, 32'hffffffff, 32'h00008000);
        rd(4'h2, 32'hffffffff, 32'h0);
        wr(4'h1, 32'h0000e000);
        wait_pend(15);
        check(32'(co.svc_level), 32'hf);
        wrap_up();
    end
endmodule : event_ctrl_test
`default_nettype wire

// ---- pipe_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// Pipeline stand-in: always accepts, retires one open event every 20 cycles
module pipe_model (
    input  wire logic core_clk,
    input  wire logic arst_n,
    input  wire logic svc_valid,
    output logic      svc_accept,
    output logic      svc_return
);
    int open_cnt;
    int tick;
    assign svc_accept = 1'b1;
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            open_cnt   <= 0;
            tick       <= 0;
            svc_return <= 1'b0;
        end else begin
            svc_return <= (tick == 19);
            tick       <= (open_cnt == 0 || tick == 19) ? 0 : tick + 1;
            open_cnt   <= open_cnt + int'(svc_valid) - int'(tick == 19);
        end
    end
endmodule : pipe_model
`default_nettype wire
